// >>> inc/pmcap_pkg.sv
// constants for the power management capability register bank
package pmcap_pkg;
    localparam logic [7:0]  PMCAP_OFS_CAPS       = 8'hdc;
    localparam logic [7:0]  PMCAP_OFS_CTRL       = 8'he0;
    localparam logic [7:0]  PMCAP_OFS_TRAIL      = 8'he4;
    localparam logic [7:0]  PMCAP_PM_CAP_ID      = 8'h01;
    localparam logic [7:0]  PMCAP_PM_NEXT_PTR    = 8'he4;
    localparam logic [7:0]  PMCAP_TRAIL_CAP_ID   = 8'h06;
    localparam logic [7:0]  PMCAP_TRAIL_NEXT_PTR = 8'h00;
    localparam logic [2:0]  PMCAP_PM_VERSION     = 3'h1;
    localparam int          PMCAP_VERSION_LSB    = 16;
    localparam logic [1:0]  PMCAP_STATE_D0       = 2'h0;
    localparam logic [1:0]  PMCAP_STATE_D3       = 2'h3;
    localparam logic [1:0]  PMCAP_STATE_RESET    = 2'h0;
    localparam int          PMCAP_RESET_PULSE_CYCLES = 16;
    typedef enum logic [1:0] {
        PMCAP_IDLE_TYPE,
        PMCAP_RESP_TYPE
    } pmcap_bus_state_type;
endpackage

// >>> logic/pmcap_reset_pulse.sv
// stretcher that turns a one-cycle trigger into an internal reset pulse
`timescale 1ns/1ps
module pmcap_reset_pulse #(
    parameter int LENGTH = 16
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic trigger,
    output logic      pulse
);
    localparam int CW = $clog2(LENGTH + 1);
    logic [CW-1:0] count;
    wire  logic    busy = (count != '0);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= '0;
            pulse <= 1'b0;
        end else begin
            if (trigger) begin
                count <= CW'(LENGTH);
            end else if (busy) begin
                count <= count - 1'b1;
            end
            pulse <= trigger | (count > CW'(1));
        end
    end
endmodule // pmcap_reset_pulse

// >>> logic/pmcap_regs.sv
// power management capability registers behind an avalon-mm slave
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - two-bit power state at bits 1:0, 00 is D0, 11 is D3, resets to D0.
// - writes of unimplemented state codes complete but leave the state unchanged.
// - a write moving D3 to D0 fires internal chip reset; secondary reset stays off.
// - capability version bits 18:16 read 001.
// - wake clock bit 19 and wake support bits 31:27 read zero.
// - auxiliary power bit 20 reads zero.
// - device-specific initialization bit 21 reads zero.
// - D1 support bit 25 and D2 support bit 26 read zero.
// - data select bits 12:9 and data scale bits 14:13 read zero.
// - wake status bit 15 reads zero and is read-only.
// - wake enable bit 8 reads zero and cannot be set.
// - entry at E4h holds read-only capability identifier in bits 7:0.
// - next pointer bits 15:8 at E4h read 00h, ending the list.
// - header at DCh carries capability identifier 01h in bits 7:0.
module pmcap_regs
    import pmcap_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             chip_reset,
    output logic             secondary_bus_reset,
    output logic [1:0]       power_state
);
    // *****************************
    // bus handshake
    // *****************************
    pmcap_bus_state_type bus_state;
    wire logic request     = avs_read | avs_write;
    wire logic accept      = request & (bus_state == PMCAP_IDLE_TYPE);
    wire logic write_take  = avs_write & accept;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_state       <= PMCAP_IDLE_TYPE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (bus_state)
                PMCAP_IDLE_TYPE: begin
                    if (request) begin
                        bus_state       <= PMCAP_RESP_TYPE;
                        avs_waitrequest <= 1'b0;
                    end
                end
                PMCAP_RESP_TYPE: begin
                    bus_state       <= PMCAP_IDLE_TYPE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state       <= PMCAP_IDLE_TYPE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // *****************************
    // address decode
    // *****************************
    wire logic [7:0] word_addr = {avs_address[7:2], 2'b00};
    wire logic hit_caps  = (word_addr == PMCAP_OFS_CAPS);
    wire logic hit_ctrl  = (word_addr == PMCAP_OFS_CTRL);
    wire logic hit_trail = (word_addr == PMCAP_OFS_TRAIL);

    // *****************************
    // power state field
    // *****************************
    wire logic [1:0] wr_state     = avs_writedata[1:0];
    wire logic       state_legal  = (wr_state == PMCAP_STATE_D0) | (wr_state == PMCAP_STATE_D3);
    wire logic       state_write  = write_take & hit_ctrl & avs_byteenable[0] & state_legal;
    wire logic [1:0] next_power_state = state_write ? wr_state : power_state;
    wire logic       wake_from_d3 = state_write & (power_state == PMCAP_STATE_D3)
                                    & (wr_state == PMCAP_STATE_D0);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_state <= PMCAP_STATE_RESET;
        end else begin
            power_state <= next_power_state;
        end
    end

    pmcap_reset_pulse #(
        .LENGTH (PMCAP_RESET_PULSE_CYCLES)
    ) u_reset_pulse (
        .ref_clk (ref_clk),
        .rst     (rst),
        .trigger (wake_from_d3),
        .pulse   (chip_reset)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            secondary_bus_reset <= 1'b0;
        end else begin
            secondary_bus_reset <= 1'b0;
        end
    end

    // *****************************
    // read data
    // *****************************
    // wake, aux, init, d1, d2 and reserved bits all stay zero
    wire logic [31:0] caps_word = {13'h0000, PMCAP_PM_VERSION, PMCAP_PM_NEXT_PTR, PMCAP_PM_CAP_ID};
    // bits 15:2 zero: wake status, data scale, data select, wake enable
    wire logic [31:0] ctrl_word  = {30'h00000000, power_state};
    wire logic [31:0] trail_word = {16'h0000, PMCAP_TRAIL_NEXT_PTR, PMCAP_TRAIL_CAP_ID};
    wire logic [31:0] read_mux   = hit_caps  ? caps_word  :
                                   hit_ctrl  ? ctrl_word  :
                                   hit_trail ? trail_word : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & accept) begin
            avs_readdata <= read_mux;
        end
    end
endmodule // pmcap_regs

// >>> tb/pmcap_assertions.sv
// checker on the power management register ports
`timescale 1ns/1ps
module pmcap_chk (
    input wire logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest,
    input wire logic        chip_reset, secondary_bus_reset,
    input wire logic [7:0]  avs_address,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [1:0]  power_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire rd  = avs_read && !avs_waitrequest;
    wire bad = avs_write && avs_waitrequest && avs_address == 8'he0 && ^avs_writedata[1:0];
    chk_sec_quiet: assert property (!secondary_bus_reset) else $error("sec reset");
    chk_state_legal: assert property (power_state inside {2'h0, 2'h3}) else $error("state");
    chk_caps_read: assert property (rd && avs_address == 8'hdc |-> avs_readdata == 32'h0001e401)
        else $error("caps");
    chk_ctrl_read: assert property (rd && avs_address == 8'he0 |-> avs_readdata == {30'h0, power_state})
        else $error("ctrl");
    chk_trail_read: assert property (rd && avs_address == 8'he4 |-> avs_readdata == 32'h6) else $error("trail");
    chk_bad_code: assert property (bad |=> $stable(power_state)) else $error("bad code");
    chk_pulse_len: assert property ($rose(chip_reset) |-> chip_reset [*8]) else $error("pulse");
    chk_pulse_cause: assert property ($rose(chip_reset) |-> $past(power_state, 2) == 2'h3 && !power_state)
        else $error("cause");
    chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait");
    cover property (rd && avs_address == 8'hdc);
    cover property (bad);
    cover property ($rose(chip_reset));
endmodule // pmcap_chk
bind pmcap_regs pmcap_chk i_chk (.*);

// >>> tb/tb_top.sv
// self-checking bench for the power management registers
`timescale 1ns/1ps
module tb_top;
    import pmcap_pkg::*;
    logic        ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [7:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hf;
    logic        avs_waitrequest, chip_reset, secondary_bus_reset;
    logic [1:0]  power_state;
    int          fails = 0, n_checks = 0, cyc = 0;
    pmcap_regs i_dut (.*);
    always #2 ref_clk = ~ref_clk;
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic t_ro();
        logic [7:0]  a[4] = '{8'hdc, 8'he0, 8'he4, 8'h40};
        logic [31:0] e[4] = '{32'h0001e401, 32'h0, 32'h6, 32'h0};
        foreach (a[i]) acc(1, a[i], 32'hfffffffc);
        foreach (a[i]) begin
            acc(0, a[i], 0);
            chk("read", e[i], q);
        end
        $display("test read-only done");
    endtask
    task automatic t_state();
        int n = 0;
        acc(1, 8'he0, 32'h3);
        for (int c = 1; c < 3; c++) begin
            acc(1, 8'he0, c);
            acc(0, 8'he0, 0);
            chk("bad code", 32'h3, q);
        end
        avs_byteenable <= 4'h0;
        acc(1, 8'he0, 0);
        avs_byteenable <= 4'hf;
        chk("masked", 32'h3, {30'h0, power_state});
        acc(1, 8'he0, 0);
        // pulse already stands at the edge where the write completes
        if (chip_reset === 1'b1) n++;
        repeat (40) begin
            @(posedge ref_clk);
            if (chip_reset === 1'b1) n++;
        end
        chk("pulse", PMCAP_RESET_PULSE_CYCLES, n);
        chk("sec", 0, {31'h0, secondary_bus_reset});
        acc(0, 8'he0, 0);
        chk("d0", 0, q);
        $display("test state done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 0;
        chk("reset", 0, {30'h0, power_state});
        t_ro();
        t_state();
        end_sim();
    end
endmodule // tb_top
